// ==== rtl/sram_port.sv ====
/*
 * pipelined synchronous static memory port: selects, two address strobes,
 * burst counter, byte-lane writes, registered data in and out, sleep.
 * assumes the driving controller runs on i_clk; output enable and sleep are
 * asynchronous pins. the data wire is resolved outside from o_dq_oe.
 */
// Functional notes
// - second select high, third low, with first
// - third select sampled low on clock edge
// - selects captured only on address loads
// - output enable low drives, high tri-states
// - first read after deselect stays tri-stated
// - advance low steps the burst address
// - processor strobe loads address and counter
// - controller strobe loads address and counter
// - both strobes low: processor strobe wins
// - processor strobe ignored while first select high
// - sleep input high holds contents, stops activity
// - input data registered on rising edge
// - read data one cycle after address
// - strap low linear, high interleaved
// - sixteen-bit word address, 64K locations
// - all-bytes write stores every lane
`timescale 1ns/10ps
module sram_port #(
	parameter int ADDR_W = sram_port_pkg::ADDR_W,
	parameter int DEPTH = sram_port_pkg::DEPTH
) (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic i_primary_chip_select_n,
	input wire logic i_expansion_select_high,
	input wire logic i_expansion_select_low_n,
	input wire logic i_processor_addr_strobe_n,
	input wire logic i_controller_addr_strobe_n,
	input wire logic i_burst_advance_n,
	input wire logic i_all_bytes_write_n,
	input wire logic i_byte_write_gate_n,
	input wire logic [sram_port_pkg::LANES-1:0] i_byte_lane_select_n,
	input wire logic i_output_enable_n,
	input wire logic i_sleep_request,
	input wire logic i_burst_order,
	input wire logic [sram_port_pkg::DATA_W-1:0] i_dq,
	output logic [sram_port_pkg::DATA_W-1:0] o_dq,
	output logic o_dq_oe,
	output logic o_asleep
);
	// ****************************************
	// state and decode
	// ****************************************
	sram_port_pkg::port_state_type st;
	sram_port_pkg::port_state_type next_st;
	logic selects_ok;
	logic proc_take;
	logic ctrl_take;
	logic new_load;
	logic write_req;
	logic active;
	logic [sram_port_pkg::LANES-1:0] lane_we;
	logic [sram_port_pkg::BURST_W-1:0] step_cnt;
	logic [sram_port_pkg::BURST_W-1:0] low_bits;
	logic [ADDR_W-1:0] acc_addr;
	logic [sram_port_pkg::DATA_W-1:0] rd_word;

	// select and strobe decode on sampled pins
	always_comb begin
		selects_ok = !i_primary_chip_select_n && i_expansion_select_high && !i_expansion_select_low_n;
		proc_take = !i_processor_addr_strobe_n && !i_primary_chip_select_n;
		ctrl_take = !i_controller_addr_strobe_n && !proc_take;
		new_load = (proc_take || ctrl_take) && !st.asleep;
	end

	// write lane decode; all-bytes write overrides byte gating
	always_comb begin
		if (!i_all_bytes_write_n) begin
			lane_we = sram_port_pkg::ALL_LANES;
		end else if (!i_byte_write_gate_n) begin
			lane_we = ~i_byte_lane_select_n;
		end else begin
			lane_we = sram_port_pkg::NO_LANES;
		end
	end

	// burst step and access address
	always_comb begin
		if (new_load) begin
			step_cnt = sram_port_pkg::CNT_RST;
			acc_addr = i_addr;
			low_bits = i_addr[sram_port_pkg::BURST_W-1:0];
		end else begin
			step_cnt = i_burst_advance_n ? st.cnt : st.cnt + 2'h1;
			low_bits = st.interleaved ? (st.addr[1:0] ^ step_cnt) : (st.addr[1:0] + step_cnt);
			acc_addr = {st.addr[ADDR_W-1:sram_port_pkg::BURST_W], low_bits};
		end
		// processor-strobe loads ignore write controls in their first cycle
		active = new_load ? selects_ok : (st.selected && !st.asleep);
		write_req = active && |lane_we && !(new_load && proc_take);
	end

	// ****************************************
	// storage: one array per byte lane
	// ****************************************
	genvar g;
	generate
		for (g = 0; g < sram_port_pkg::LANES; g++) begin : g_lane
			logic [sram_port_pkg::LANE_W-1:0] lane_mem [DEPTH];
			// lane write and asynchronous array read
			always_ff @(posedge i_clk) begin
				if (write_req && lane_we[g]) begin
					lane_mem[acc_addr] <= i_dq[g*sram_port_pkg::LANE_W +: sram_port_pkg::LANE_W];
				end
			end
			assign rd_word[g*sram_port_pkg::LANE_W +: sram_port_pkg::LANE_W] = lane_mem[acc_addr];
		end
	endgenerate

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		next_st = st;
		// sleep pin passes two flops first
		next_st.sleep_sync = {st.sleep_sync[0], i_sleep_request};
		next_st.asleep = st.sleep_sync[sram_port_pkg::SYNC_LAST];
		// strap caught once at the first edge after reset
		if (!st.mode_known) begin
			next_st.mode_known = 1'b1;
			next_st.interleaved = i_burst_order;
		end
		next_st.data_in = i_dq;
		if (st.asleep) begin
			next_st.drive = 1'b0;
		end else begin
			if (new_load) begin
				next_st.selected = selects_ok;
				next_st.addr = i_addr;
				next_st.cnt = sram_port_pkg::CNT_RST;
				next_st.by_processor = proc_take;
			end else if (st.selected) begin
				next_st.cnt = step_cnt;
			end
			// read data lands one edge after its address
			if (active && !write_req) begin
				next_st.data_out = rd_word;
				next_st.drive = !(new_load && !st.selected);
			end else begin
				next_st.drive = 1'b0;
			end
		end
	end

	// register the whole state
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			st <= '{addr: sram_port_pkg::ADDR_RST, cnt: sram_port_pkg::CNT_RST, selected: 1'b0,
				by_processor: 1'b0, data_in: sram_port_pkg::DATA_RST, data_out: sram_port_pkg::DATA_RST,
				drive: 1'b0, mode_known: 1'b0, interleaved: 1'b1, sleep_sync: sram_port_pkg::SYNC_RST,
				asleep: 1'b0};
		end else begin
			st <= next_st;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	// output enable gates the driver without waiting for a clock
	assign o_dq = st.data_out;
	assign o_dq_oe = st.drive && !i_output_enable_n;
	assign o_asleep = st.asleep;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	property p_select_capture;
		new_load |=> st.selected == $past(selects_ok);
	endproperty
	a_select_capture: assert property (p_select_capture) else $error("select not captured on load");

	property p_third_select;
		new_load && i_expansion_select_low_n |=> !st.selected;
	endproperty
	a_third_select: assert property (p_third_select) else $error("third select high still selected");

	property p_select_hold;
		!new_load && !st.asleep |=> $stable(st.selected) && $stable(st.addr);
	endproperty
	a_select_hold: assert property (p_select_hold) else $error("selection changed without load");

	// never drives with output enable high; a selected read with no write controls drives next cycle
	property p_oe_gate;
		(o_dq_oe |-> !i_output_enable_n) and
			(!st.asleep && st.selected && (!new_load || selects_ok) && lane_we == sram_port_pkg::NO_LANES
			##1 !i_output_enable_n |-> o_dq_oe);
	endproperty
	a_oe_gate: assert property (p_oe_gate) else $error("driving with output enable high");

	property p_first_read_mask;
		new_load && !st.selected && !st.asleep |=> !o_dq_oe;
	endproperty
	a_first_read_mask: assert property (p_first_read_mask) else $error("first read after deselect driven");

	property p_advance;
		!new_load && st.selected && !st.asleep && !i_burst_advance_n |=> st.cnt == $past(st.cnt) + 2'h1;
	endproperty
	a_advance: assert property (p_advance) else $error("burst counter did not step");

	property p_proc_load;
		proc_take && !st.asleep |=> st.addr == $past(i_addr) && st.cnt == 2'h0 && st.by_processor;
	endproperty
	a_proc_load: assert property (p_proc_load) else $error("processor strobe load wrong");

	property p_ctrl_load;
		ctrl_take && !st.asleep |=> st.addr == $past(i_addr) && !st.by_processor;
	endproperty
	a_ctrl_load: assert property (p_ctrl_load) else $error("controller strobe load wrong");

	property p_priority;
		!i_processor_addr_strobe_n && !i_controller_addr_strobe_n && !i_primary_chip_select_n
			&& !st.asleep |=> st.by_processor;
	endproperty
	a_priority: assert property (p_priority) else $error("controller strobe won over processor");

	property p_proc_ignored;
		i_primary_chip_select_n && i_controller_addr_strobe_n |-> !new_load;
	endproperty
	a_proc_ignored: assert property (p_proc_ignored) else $error("processor strobe taken with first select high");

	property p_sleep_quiet;
		st.asleep |=> !st.drive && $stable(st.addr);
	endproperty
	a_sleep_quiet: assert property (p_sleep_quiet) else $error("activity while asleep");

	property p_strap_fixed;
		st.mode_known |=> $stable(st.interleaved);
	endproperty
	a_strap_fixed: assert property (p_strap_fixed) else $error("burst order changed after start");

	property p_all_bytes;
		!i_all_bytes_write_n |-> lane_we == sram_port_pkg::ALL_LANES;
	endproperty
	a_all_bytes: assert property (p_all_bytes) else $error("all-bytes write missed a lane");
endmodule

// ==== common/sram_port_pkg.sv ====
/*
 * shared constants and state layout for the pipelined synchronous memory port.
 * assumes one clock domain; sizes below match a 64K x 32 array in four byte lanes.
 */
package sram_port_pkg;
	// ****************************************
	// geometry
	// ****************************************
	localparam int ADDR_W = 16;
	localparam int DATA_W = 32;
	localparam int LANES = 4;
	localparam int LANE_W = 8;
	localparam int BURST_W = 2;
	localparam int DEPTH = 65536;
	// ****************************************
	// reset values and field positions
	// ****************************************
	localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;
	localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;
	localparam logic [BURST_W-1:0] CNT_RST = 2'h0;
	localparam logic [LANES-1:0] ALL_LANES = 4'hF;
	localparam logic [LANES-1:0] NO_LANES = 4'h0;
	localparam logic [1:0] SYNC_RST = 2'h0;
	localparam int SYNC_LAST = 1;
	// ****************************************
	// whole state of the port, registered once per clock
	// ****************************************
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [BURST_W-1:0] cnt;
		logic selected;
		logic by_processor;
		logic [DATA_W-1:0] data_in;
		logic [DATA_W-1:0] data_out;
		logic drive;
		logic mode_known;
		logic interleaved;
		logic [1:0] sleep_sync;
		logic asleep;
	} port_state_type;
endpackage

// ==== bench/dq_bus_model.sv ====
/*
 * partner model of the shared data wire between the port and its controller.
 * assumes the port and the bench share i_clk; the wire has no pull resistor.
 */
`timescale 1ns/10ps
module dq_bus_model (
	input wire logic i_clk,
	input wire logic [sram_port_pkg::DATA_W-1:0] i_port_dq,
	input wire logic i_port_oe,
	input wire logic [sram_port_pkg::DATA_W-1:0] i_host_dq,
	input wire logic i_host_en,
	output logic [sram_port_pkg::DATA_W-1:0] o_wire
);
	logic [sram_port_pkg::DATA_W-1:0] last = 32'h0000_0000;
	// remember the wire so a released wire shows its inverse
	always_ff @(posedge i_clk) begin
		last <= o_wire;
	end
	// port drive first, then host write data, else floating pattern
	assign o_wire = i_port_oe ? i_port_dq : (i_host_en ? i_host_dq : ~last);
endmodule

// ==== bench/tb.sv ====
/*
 * self-checking bench for the memory port: writes, bursts, byte lanes, strobe priority, sleep.
 * assumes the port package is compiled first and dq_bus_model resolves the data wire.
 */
`timescale 1ns/10ps
module tb;
	// ****************************************
	// stimulus and observed signals
	// ****************************************
	// select pin sets {first_n, second, third_n}: all on, or one select off
	localparam logic [2:0] SEL_ON = 3'h2;
	localparam logic [2:0] SEL_OFF1 = 3'h6;
	localparam logic [2:0] SEL_OFF2 = 3'h0;
	localparam logic [2:0] SEL_OFF3 = 3'h3;
	logic clk = 1'h0, rst, cs1n = 1'h1, cs2 = 1'h0, cs3n = 1'h1, psn = 1'h1, csn = 1'h1, advn = 1'h1;
	logic gwn = 1'h1, bwen = 1'h1, oen = 1'h1, sleep_pin = 1'h0, mode, wen = 1'h0, oe, slp;
	logic [3:0] bwn = 4'hF;
	logic [15:0] addr = 16'h0000;
	logic [31:0] wdat = 32'h0000_0000, dq, qo;
	int num_errors = 0, total_checks = 0, cycles = 0;
	// clock
	initial begin
		forever #50 clk = ~clk;
	end
	// hang guard, far above the 54 cycles the scenarios need
	always @(posedge clk) begin
		cycles++;
		if (cycles == 4000) begin
			num_errors++;
			$display("[FAIL] %0t timeout", $time);
			finish_test();
		end
	end
	sram_port u_sram_port (.i_clk(clk), .i_sys_rst(rst), .i_addr(addr), .i_primary_chip_select_n(cs1n),
		.i_expansion_select_high(cs2), .i_expansion_select_low_n(cs3n), .i_processor_addr_strobe_n(psn),
		.i_controller_addr_strobe_n(csn), .i_burst_advance_n(advn), .i_all_bytes_write_n(gwn),
		.i_byte_write_gate_n(bwen), .i_byte_lane_select_n(bwn), .i_output_enable_n(oen),
		.i_sleep_request(sleep_pin), .i_burst_order(mode), .i_dq(dq), .o_dq(qo), .o_dq_oe(oe), .o_asleep(slp));
	dq_bus_model u_dq_bus_model (.i_clk(clk), .i_port_dq(qo), .i_port_oe(oe), .i_host_dq(wdat),
		.i_host_en(wen), .o_wire(dq));
	// ****************************************
	// shared tasks
	// ****************************************
	task step;
		@(posedge clk);
		#10;
	endtask
	task chk_word(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t word %h expected %h", $time, got, exp);
		end
	endtask
	task chk_bit(input logic got, input logic exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t flag %b expected %b", $time, got, exp);
		end
	endtask
	function automatic logic [31:0] val(input logic [15:0] a);
		return {16'hC35A, a};
	endfunction
	// every pin but reset, strap and sleep set at most once per cycle, just after the edge
	task drv(input logic [15:0] a, input logic ps, input logic cs, input logic [2:0] sel, input logic burst_advance_n,
		input logic gw, input logic bw, input logic [3:0] ln, input logic oe_n, input logic [31:0] d, input logic en);
		addr = a;
		psn = ~ps;
		csn = ~cs;
		{cs1n, cs2, cs3n} = sel;
		advn = ~burst_advance_n;
		gwn = ~gw;
		bwen = ~bw;
		bwn = ln;
		oen = oe_n;
		wdat = d;
		wen = en;
	endtask
	// single-cycle write by controller strobe; g low gives a byte-lane write
	task wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] ln, input logic g);
		drv(a, 1'h0, 1'h1, SEL_ON, 1'h0, g, ~g, ln, 1'h1, d, 1'h1);
		step;
	endtask
	// load with one select off: leaves the port deselected
	task desel(input logic [15:0] a, input logic [2:0] sel, input logic p);
		drv(a, p, ~p, sel, 1'h0, 1'h0, 1'h0, 4'hF, 1'h1, 32'h0000_0000, 1'h0);
		step;
	endtask
	// single read entered from the deselected state
	task rd(input logic [15:0] a, input logic [31:0] e);
		desel(a, SEL_OFF3, 1'h0);
		drv(a, 1'h0, 1'h1, SEL_ON, 1'h0, 1'h0, 1'h0, 4'hF, 1'h0, 32'h0000_0000, 1'h0);
		step;
		chk_bit(oe, 1'h0);
		chk_word(qo, e);
		desel(a, SEL_OFF2, 1'h0);
	endtask
	// strap only changes while reset is held
	task rst_seq(input logic m);
		rst = 1'h1;
		mode = m;
		repeat (3) step;
		rst = 1'h0;
	endtask
	// ****************************************
	// scenarios
	// ****************************************
	task burst(input logic lin);
		logic [15:0] a;
		int i;
		for (i = 0; i < 4; i++) wr(16'h1234 + 16'(i), val(16'h1234 + 16'(i)), 4'hF, 1'h1);
		desel(16'h1235, SEL_OFF2, ~lin);
		drv(16'h1235, ~lin, lin, SEL_ON, 1'h0, 1'h0, 1'h0, 4'hF, 1'h0, 32'h0000_0000, 1'h0);
		step;
		chk_bit(oe, 1'h0);
		chk_word(qo, val(16'h1235));
		// continuations with the selects off and a stray address: both ignored
		for (i = 1; i < 4; i++) begin
			drv(16'h0000, 1'h0, 1'h0, SEL_OFF1, 1'h1, 1'h0, 1'h0, 4'hF, 1'h0, 32'h0000_0000, 1'h0);
			step;
			a = {14'h048D, lin ? 2'(1 + i) : 2'(1 ^ i)};
			chk_word(qo, val(a));
			chk_bit(oe, 1'h1);
		end
		// output enable released between edges, then a deselect load
		drv(16'h0000, 1'h0, 1'h1, SEL_OFF2, 1'h0, 1'h0, 1'h0, 4'hF, 1'h1, 32'h0000_0000, 1'h0);
		#1;
		chk_bit(oe, 1'h0);
		step;
	endtask
	task lanes;
		wr(16'h0100, 32'h1122_3344, 4'hF, 1'h1);
		wr(16'h0100, 32'hAABB_CCDD, 4'hA, 1'h0);
		rd(16'h0100, 32'h11BB_33DD);
	endtask
	task strobe_gate;
		wr(16'h0300, val(16'h0300), 4'hF, 1'h1);
		// processor strobe with first select high: a plain continuation
		drv(16'h0301, 1'h1, 1'h0, SEL_OFF1, 1'h0, 1'h0, 1'h0, 4'hF, 1'h0, 32'h0000_0000, 1'h0);
		step;
		chk_bit(oe, 1'h1);
		chk_word(qo, val(16'h0300));
		// controller strobe with first select high deselects
		drv(16'h0301, 1'h0, 1'h1, SEL_OFF1, 1'h0, 1'h0, 1'h0, 4'hF, 1'h0, 32'h0000_0000, 1'h0);
		step;
		chk_bit(oe, 1'h0);
	endtask
	task prio;
		wr(16'h0777, val(16'h0777), 4'hF, 1'h1);
		// both strobes with a global write: processor load wins and ignores the write
		drv(16'h0777, 1'h1, 1'h1, SEL_ON, 1'h0, 1'h1, 1'h0, 4'hF, 1'h1, ~val(16'h0777), 1'h1);
		step;
		rd(16'h0777, val(16'h0777));
		// processor-strobe write lands on the following edge
		drv(16'h0778, 1'h1, 1'h0, SEL_ON, 1'h0, 1'h0, 1'h0, 4'hF, 1'h1, 32'h0000_0000, 1'h0);
		step;
		drv(16'h0000, 1'h0, 1'h0, SEL_OFF1, 1'h0, 1'h1, 1'h0, 4'hF, 1'h1, val(16'h0778), 1'h1);
		step;
		rd(16'h0778, val(16'h0778));
	endtask
	task sleep;
		sleep_pin = 1'h1;
		repeat (3) step;
		chk_bit(slp, 1'h1);
		// a write while asleep must not reach the array
		wr(16'h0100, 32'h0000_0000, 4'hF, 1'h1);
		drv(16'h0100, 1'h0, 1'h0, SEL_OFF2, 1'h0, 1'h0, 1'h0, 4'hF, 1'h1, 32'h0000_0000, 1'h0);
		sleep_pin = 1'h0;
		repeat (3) step;
		chk_bit(slp, 1'h0);
		rd(16'h0100, 32'h11BB_33DD);
	endtask
	task finish_test;
		if (num_errors == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// main sequence: linear strap first, then interleaved after a mid-run reset
	initial begin
		rst_seq(1'h0);
		burst(1'h1);
		rst_seq(1'h1);
		burst(1'h0);
		lanes;
		strobe_gate;
		prio;
		sleep;
		finish_test;
	end
endmodule
